// File: src/lcc_pkg.sv
// lcc_pkg: constants, types and register map for the logic cell cluster
// assumes a single 200 MHz clock domain and an AHB-Lite register slave
//
// Behaviour
// - cell register works as D, T, JK or SR
// - combinational cell bypasses its register
// - chains link only cells two to ten
// - carry-in feeds lookup table and next stage
// - long carry continues two clusters further on
// - carry chain never crosses row middle
// - n-bit adder uses n+1 cells, carry routed
// - cascade ANDs or ORs, four inputs per cell
// - OR cascade cells cannot use their registers
// - long cascade skips alternate clusters, same parity
// - cascade chain never crosses row centre
// - normal mode: four-input table, carry or input three
// - arithmetic mode: sum table plus carry table
// - counter: enable, up/down, cluster clear and load
// - counter: two tables, load mux, clear AND
// - clear beats load beats cascade
// - only cell two has register feedback mux
// - cells 1-5 drive right, 6-10 left
// - first cell makes cluster clear and load
package lcc_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int LCC_NUM_CELLS = 10;
	localparam int LCC_HALF_CELLS = 5;
	localparam int LCC_ROW_HALF_LAST = 11;
	localparam int LCC_CHAIN_SKIP = 2;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] LCC_CELL_CFG_BASE = 8'h00;
	localparam logic [7:0] LCC_CTRL_ADDR = 8'h28;
	localparam logic [7:0] LCC_STATUS_ADDR = 8'h2c;
	localparam logic [25:0] LCC_CFG_RESET = 26'h0000000;
	localparam int LCC_CTRL_EN_BIT = 0;
	localparam int LCC_STAT_SCLR_BIT = 10;
	localparam int LCC_STAT_SLOAD_BIT = 11;
	localparam int LCC_CFG_WIDTH = 26;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR} lcc_ff_e;
	typedef enum logic [1:0] {LCC_MODE_NORMAL, LCC_MODE_ARITH, LCC_MODE_COUNTER} lcc_mode_e;

	typedef struct packed {
		logic cout_route;
		logic fb_sel;
		logic carry_sel;
		logic casc_or;
		logic casc_en;
		logic bypass;
		lcc_mode_e mode;
		lcc_ff_e ff;
		logic [15:0] mask;
	} lcc_cfg_s;

	typedef struct packed {
		logic cell_input_one;
		logic cell_input_three;
	} lcc_left_s;

	typedef struct packed {
		logic cell_input_two;
		logic cell_input_four;
	} lcc_right_s;

	typedef struct packed {
		logic carry;
		logic casc;
	} lcc_chain_s;

endpackage

// File: src/lcc_cluster.sv
// lcc_cluster: one cluster of ten logic cells with carry and cascade chains
// assumes neighbour clusters wire chain_out of cluster k to chain_in of k+2
`timescale 1ns/10ps

module lcc_cluster
	import lcc_pkg::*;
#(
	parameter int CLUSTER_IDX = 1
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire lcc_left_s [LCC_NUM_CELLS-1:0] left_in,
	input wire lcc_right_s [LCC_NUM_CELLS-1:0] right_in,
	input wire lcc_chain_s chain_in,
	output lcc_chain_s chain_out_q,
	output logic [LCC_HALF_CELLS-1:0] drive_right_q,
	output logic [LCC_HALF_CELLS-1:0] drive_left_q
);

	// ----------------------------------------------------------------
	// chain position in the row
	// ----------------------------------------------------------------
	localparam bit IN_OK = (CLUSTER_IDX > LCC_CHAIN_SKIP) &&
		((CLUSTER_IDX <= LCC_ROW_HALF_LAST) == (CLUSTER_IDX - LCC_CHAIN_SKIP <= LCC_ROW_HALF_LAST));
	localparam bit OUT_OK = (CLUSTER_IDX <= LCC_ROW_HALF_LAST) ==
		(CLUSTER_IDX + LCC_CHAIN_SKIP <= LCC_ROW_HALF_LAST);

	lcc_cfg_s cfg_q [LCC_NUM_CELLS];
	logic ctrl_en_q;
	logic [LCC_NUM_CELLS-1:0] q_q;
	logic [LCC_NUM_CELLS-1:0] cin;
	logic [LCC_NUM_CELLS-1:0] cout;
	logic [LCC_NUM_CELLS-1:0] cas_in;
	logic [LCC_NUM_CELLS-1:0] cas_out;
	logic [LCC_NUM_CELLS-1:0] cell_out;
	logic [LCC_NUM_CELLS-1:0] q_d;
	logic sclr;
	logic sload;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic addr_phase;

	assign addr_phase = hsel && hready && htrans[1];

	function automatic logic [31:0] read_word(input logic [7:0] a, input lcc_cfg_s c [LCC_NUM_CELLS],
		input logic en, input logic [LCC_NUM_CELLS-1:0] q, input logic clr, input logic ld);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < LCC_NUM_CELLS; i++)
		begin
			if (a == LCC_CELL_CFG_BASE + 8'(4 * i))
			begin
				r = {6'h00, c[i]};
			end
		end
		if (a == LCC_CTRL_ADDR)
		begin
			r[LCC_CTRL_EN_BIT] = en;
		end
		else if (a == LCC_STATUS_ADDR)
		begin
			r[LCC_NUM_CELLS-1:0] = q;
			r[LCC_STAT_SCLR_BIT] = clr;
			r[LCC_STAT_SLOAD_BIT] = ld;
		end
		return r;
	endfunction

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end
		else if (rd_pend_q)
		begin
			rd_pend_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_phase && hwrite;
			rd_pend_q <= addr_phase && !hwrite;
			if (addr_phase)
			begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// reads take one wait state so pending writes land first
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= !(addr_phase && !hwrite && !rd_pend_q);
			hresp <= 1'b0;
			if (rd_pend_q)
			begin
				hrdata <= read_word(addr_q, cfg_q, ctrl_en_q, q_q, sclr, sload);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < LCC_NUM_CELLS; i++)
			begin
				cfg_q[i] <= lcc_cfg_s'(LCC_CFG_RESET);
			end
			ctrl_en_q <= 1'b0;
		end
		else if (wr_pend_q)
		begin
			for (int i = 0; i < LCC_NUM_CELLS; i++)
			begin
				if (addr_q == LCC_CELL_CFG_BASE + 8'(4 * i))
				begin
					cfg_q[i] <= lcc_cfg_s'(hwdata[LCC_CFG_WIDTH-1:0]);
				end
			end
			if (addr_q == LCC_CTRL_ADDR)
			begin
				ctrl_en_q <= hwdata[LCC_CTRL_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// cluster control from the first cell
	// ----------------------------------------------------------------
	assign sclr = ctrl_en_q && left_in[0].cell_input_one;
	assign sload = ctrl_en_q && right_in[0].cell_input_two;

	// ----------------------------------------------------------------
	// logic cells
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LCC_NUM_CELLS; g++)
		begin : g_cell
			logic d1;
			logic d2;
			logic d3;
			logic d4;
			logic fbk;
			logic f;
			logic gv;
			logic nx;
			logic [3:0] idx4;
			logic [2:0] idx3;

			assign d1 = left_in[g].cell_input_one;
			assign d3 = left_in[g].cell_input_three;
			assign d2 = right_in[g].cell_input_two;
			assign d4 = right_in[g].cell_input_four;

			// first cell stays off both chains
			if (g == 0)
			begin : g_head
				assign cin[g] = 1'b0;
				assign cas_in[g] = !cfg_q[g].casc_or;
			end
			else if (g == 1)
			begin : g_entry
				assign cin[g] = IN_OK && chain_in.carry;
				assign cas_in[g] = IN_OK ? chain_in.casc : !cfg_q[g].casc_or;
			end
			else
			begin : g_body
				assign cin[g] = cout[g-1];
				assign cas_in[g] = cas_out[g-1];
			end

			// feedback mux exists only in the second cell
			if (g == 1)
			begin : g_fb
				assign fbk = cfg_q[g].fb_sel ? q_q[g] : d1;
			end
			else
			begin : g_nofb
				assign fbk = d1;
			end

			always_comb
			begin
				idx4 = {d4, cfg_q[g].carry_sel ? cin[g] : d3, d2, fbk};
				idx3 = {cin[g], d2, fbk};
				cout[g] = 1'b0;
				case (cfg_q[g].mode)
					LCC_MODE_ARITH,
					LCC_MODE_COUNTER:
					begin
						f = cfg_q[g].mask[{1'b0, idx3}];
						cout[g] = cfg_q[g].mask[{1'b1, idx3}];
					end
					default:
					begin
						f = cfg_q[g].mask[idx4];
					end
				endcase
				if (cfg_q[g].cout_route)
				begin
					f = cin[g];
				end
				if (!cfg_q[g].casc_en)
				begin
					gv = f;
				end
				else if (cfg_q[g].casc_or)
				begin
					gv = f | cas_in[g];
				end
				else
				begin
					gv = f & cas_in[g];
				end
				cas_out[g] = gv;
			end

			always_comb
			begin
				case (cfg_q[g].ff)
					LCC_FF_T: nx = q_q[g] ^ gv;
					LCC_FF_JK: nx = (gv & !q_q[g]) | (!d4 & q_q[g]);
					LCC_FF_SR: nx = gv | (!d4 & q_q[g]);
					default: nx = gv;
				endcase
				// counter relies on the cluster holding no unrelated registers
				if (cfg_q[g].mode == LCC_MODE_COUNTER)
				begin
					nx = d4 ? gv : q_q[g];
					if (sload)
					begin
						nx = d3;
					end
				end
				q_d[g] = nx & !sclr;
			end

			// OR cascade cannot use the register
			assign cell_out[g] = (cfg_q[g].bypass || (cfg_q[g].casc_en && cfg_q[g].casc_or)) ? gv : q_q[g];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q_q <= '0;
		end
		else
		begin
			q_q <= q_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drive_right_q <= '0;
			drive_left_q <= '0;
			chain_out_q <= '0;
		end
		else
		begin
			drive_right_q <= cell_out[LCC_HALF_CELLS-1:0];
			drive_left_q <= cell_out[LCC_NUM_CELLS-1:LCC_HALF_CELLS];
			chain_out_q.carry <= OUT_OK && cout[LCC_NUM_CELLS-1];
			chain_out_q.casc <= OUT_OK && cas_out[LCC_NUM_CELLS-1];
		end
	end

endmodule // lcc_cluster

// File: dv/lcc_cluster_asserts.sv
// lcc_chk: bus and chain checks on every lcc_cluster
// assumes one clock and hready tied to hreadyout
`timescale 1ns/10ps
module lcc_chk
	import lcc_pkg::*;
#(
	parameter int CLUSTER_IDX = 1
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire lcc_chain_s chain_out_q
);
	logic rd_acc;
	logic wr_acc;
	logic unmap_q;
	assign rd_acc = hsel && hready && htrans[1] && !hwrite;
	assign wr_acc = hsel && hready && htrans[1] && hwrite;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			unmap_q <= 1'b0;
		else if (rd_acc)
			unmap_q <= haddr[7:0] > 8'h2c;
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_rd_wait; rd_acc |=> s_wait; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_fast; wr_acc |=> hreadyout ##1 (hreadyout || $past(rd_acc)); endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	property p_wait_cause; !hreadyout |-> $past(rd_acc); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
	property p_wait_once; !hreadyout |=> hreadyout; endproperty
	a_wait_once: assert property (p_wait_once) else $error("long wait");
	property p_rd_hold; !$stable(hrdata) |-> $past(rd_acc, 2); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmap; rd_acc ##1 unmap_q |-> ##1 hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_mid_row; (CLUSTER_IDX == 10 || CLUSTER_IDX == 11) |-> chain_out_q == '0; endproperty
	a_mid_row: assert property (p_mid_row) else $error("chain crosses middle");
endmodule // lcc_chk

bind lcc_cluster lcc_chk #(.CLUSTER_IDX(CLUSTER_IDX)) u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .chain_out_q(chain_out_q));

// File: dv/lcc_nbr_model.sv
// lcc_nbr_model: cluster two places down, feeds chain_in
// assumes bench sets carry and cascade levels after clk edges
`timescale 1ns/10ps
module lcc_nbr_model
	import lcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire lcc_chain_s req,
	output lcc_chain_s chain_q
);
	// one registered hop per cluster
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			chain_q <= '0;
		else
			chain_q <= req;
endmodule // lcc_nbr_model

// File: dv/test_logic_cell_cluster_chains.sv
// test_logic_cell_cluster_chains: directed bench for cluster three
// assumes lcc_cluster, lcc_nbr_model and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t %h", $time, a); end end
module test_logic_cell_cluster_chains
	import lcc_pkg::*;
;
	logic clk, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans;
	lcc_left_s [LCC_NUM_CELLS-1:0] left_in;
	lcc_right_s [LCC_NUM_CELLS-1:0] right_in;
	lcc_chain_s chain_in, req, chain_o, chain_mid;
	logic [4:0] drv_r, drv_l;
	int errors, comparisons, cyc;

	lcc_cluster #(.CLUSTER_IDX(3)) u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .left_in(left_in), .right_in(right_in),
		.chain_in(chain_in), .chain_out_q(chain_o), .drive_right_q(drv_r), .drive_left_q(drv_l));
	// cluster at the row middle, same bus and chain; its chain out must stay quiet
	lcc_cluster #(.CLUSTER_IDX(11)) u_dut_mid (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(), .hresp(), .hrdata(), .left_in(left_in), .right_in(right_in),
		.chain_in(chain_in), .chain_out_q(chain_mid), .drive_right_q(), .drive_left_q());
	lcc_nbr_model u_nbr (.clk(clk), .rst_b(rst_b), .req(req), .chain_q(chain_in));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			results();
		end
	end

	// ----
	// bus and helpers
	// ----
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task results;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs;
		`CHK(hreadyout, 1'b1)
		`CHK(drv_r, 5'h00)
		rdc(8'h2c, 32'h0);
		rdc(8'h28, 32'h0);
		wr(8'h24, 32'hffffffff);
		rdc(8'h24, 32'h03ffffff);
		wr(8'h24, 32'h0);
		wr(8'h30, 32'hffffffff);
		rdc(8'h30, 32'h0);
		$display("register test done");
	endtask
	task automatic t_flops;
		wr(8'h00, 32'h0010aaaa); // cell 1 bypassed
		wr(8'h04, 32'h0003ffff); // cell 2 SR
		wr(8'h08, 32'h0000aaaa); // cell 3 D
		wr(8'h0c, 32'h0001ffff); // cell 4 T
		wr(8'h10, 32'h0002ffff); // cell 5 JK
		@(posedge clk);
		left_in[0].cell_input_one <= 1'b1;
		left_in[2].cell_input_one <= 1'b1;
		right_in[1].cell_input_four <= 1'b1;
		right_in[4].cell_input_four <= 1'b1;
		step(2);
		`CHK(drv_r[0], 1'b1)
		`CHK(drv_r[2], 1'b0)
		`CHK(drv_r[1], 1'b1)
		rdat[1:0] = drv_r[4:3];
		step(1);
		`CHK(drv_r[2], 1'b1)
		`CHK(drv_r[4:3], ~rdat[1:0])
		$display("flop test done");
	endtask
	task automatic t_chain;
		// cell 2 arith bypassed: sum and carry both follow carry-in
		wr(8'h04, 32'h0014f0f0);
		// cells 3 to 10 arith: carry-out follows carry-in
		for (int i = 2; i < LCC_NUM_CELLS; i++)
			wr(8'(4 * i), 32'h0004f000);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			req.carry <= (i == 0);
			step(3);
			`CHK(drv_r[1], (i == 0))
			`CHK(chain_o.carry, (i == 0))
			`CHK(chain_mid.carry, 1'b0)
		end
		$display("chain test done");
	endtask
	task automatic t_clear;
		// cells outside the counters only combinational
		for (int i = 3; i < LCC_NUM_CELLS; i++)
			if (i != 5)
				wr(8'(4 * i), 32'h00100000);
		@(posedge clk);
		left_in[0].cell_input_one <= 1'b0;
		left_in[2].cell_input_three <= 1'b1;
		left_in[5].cell_input_three <= 1'b1;
		right_in[0].cell_input_two <= 1'b1;
		wr(8'h08, 32'h0008ffff);
		wr(8'h14, 32'h00080000);
		wr(8'h28, 32'h1);
		step(3);
		`CHK(drv_r[2], 1'b1)
		`CHK(drv_l[0], 1'b1)
		left_in[0].cell_input_one <= 1'b1;
		step(3);
		`CHK(drv_r[2], 1'b0)
		`CHK(drv_l[0], 1'b0)
		rdc(8'h2c, 32'h00000c00);
		$display("clear test done");
	endtask

	initial
	begin
		rst_b = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		left_in = '0;
		right_in = '0;
		req = '0;
		step(20);
		rst_b <= 1'b1;
		t_regs();
		t_flops();
		t_chain();
		t_clear();
		results();
	end
endmodule // test_logic_cell_cluster_chains
